// ### rtl/ecci_bit_flip.sv
// Single data bit inverter addressed by a binary bit index
`timescale 1ns/1ps

module ecci_bit_flip #(
	parameter int DATA_W = 32,
	parameter int IDX_W  = 16
) (
	input  wire logic [DATA_W-1:0] data_in,
	input  wire logic              flip_en,
	input  wire logic [IDX_W-1:0]  flip_idx,
	output logic      [DATA_W-1:0] data_out
);

	logic [DATA_W-1:0] flip_mask;

	// One-hot mask; an index beyond the data width flips nothing
	always_comb begin
		for (int i = 0; i < DATA_W; i++) begin
			flip_mask[i] = flip_en && (flip_idx == IDX_W'(i));
		end
	end

	assign data_out = data_in ^ flip_mask;

endmodule : ecci_bit_flip

// ### rtl/ecci_monitor.sv
// ECC error injection, error capture and per-RAM interrupt control
`timescale 1ns/1ps

// What this block does
// - The upper half of the first inject register holds the bit index inverted on injection.
// - The lower half holds the row where injection applies, ignored in force-next-read mode.
// - Double injection also inverts the bit indexed by the low half of the second register.
// - A detected single or double error records its row in the upper half of status one.
// - The single flag sets on detection or a written 1 at bit 0 and clears by a 1 at bit 8.
// - The double flag sets on detection or a written 1 at bit 1 and clears by a 1 at bit 9.
// - The successive flag sets on a single error during writeback, by bit 2, clears by bit 10.
// - Bits 10 to 8 read as the three pending flags and a written 1 clears them.
// - The failing bit index of a single error is shown in the low half of status two.
// - After an interrupt no further one is sent until software writes the acknowledge register.
// - A read-only 19-bit vector shows each RAM's pending level, ALE at bit 0, ports after.
// - A 1 written to the enable-set field enables that RAM's interrupt, a 0 changes nothing.
// - A 1 written to the enable-clear field disables that RAM's interrupt, a 0 changes nothing.
// - Control bits 3 and 4 request single and double injection, self-clearing in one-shot mode.
// - Control bit 5 makes the requested error land on the next read whatever its row.
module ecci_monitor
	import ecci_pkg::*;
#(
	parameter int DATA_W   = 32,
	parameter int NUM_RAMS = 19
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic [7:0]        reg_addr,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [31:0]       reg_wdata,
	output logic      [31:0]       reg_rdata,
	output logic                   reg_rvalid,
	input  wire logic              ram_rd_valid,
	input  wire logic [15:0]       ram_rd_row,
	input  wire logic [DATA_W-1:0] ram_rd_data,
	output logic                   ram_out_valid,
	output logic      [DATA_W-1:0] ram_out_data,
	output logic                   ram_out_injected,
	input  wire logic              det_single,
	input  wire logic              det_double,
	input  wire logic [15:0]       det_row,
	input  wire logic [15:0]       det_bit,
	input  wire logic              wb_pending,
	input  wire logic              wb_done,
	input  wire logic [NUM_RAMS-1:0] ram_pending_in,
	output logic                   irq
);

	// ==========================================================
	// Elaboration checks
	if (DATA_W < 2 || DATA_W > 65536) begin : g_bad_width
		$error("DATA_W must be 2 to 65536");
	end
	if (NUM_RAMS < 1 || NUM_RAMS > 32) begin : g_bad_rams
		$error("NUM_RAMS must be 1 to 32");
	end

	// ==========================================================
	// State
	logic [ECCI_CTL_W-1:0]  ctrl_reg,      ctrl_next;
	logic [ECCI_HALF_W-1:0] inj_row_reg,   inj_row_next;
	logic [ECCI_HALF_W-1:0] inj_bit1_reg,  inj_bit1_next;
	logic [ECCI_HALF_W-1:0] inj_bit2_reg,  inj_bit2_next;
	logic [ECCI_HALF_W-1:0] err_row_reg,   err_row_next;
	logic [ECCI_HALF_W-1:0] err_bit_reg,   err_bit_next;
	logic [2:0]             flags_reg,     flags_next;
	logic                   wb_armed_reg,  wb_armed_next;
	logic [NUM_RAMS-1:0]    pending_reg;
	logic [NUM_RAMS-1:0]    enable_reg,    enable_next;
	logic                   irq_reg,       irq_next;
	logic [31:0]            rdata_reg;
	logic                   rvalid_reg;
	logic                   out_valid_reg;
	logic [DATA_W-1:0]      out_data_reg;
	logic                   out_inj_reg;

	// ==========================================================
	// Register write decode
	wire wr_ctrl   = reg_wr && (reg_addr == ECCI_OFF_CTRL);
	wire wr_inj1   = reg_wr && (reg_addr == ECCI_OFF_INJ1);
	wire wr_inj2   = reg_wr && (reg_addr == ECCI_OFF_INJ2);
	wire wr_stat1  = reg_wr && (reg_addr == ECCI_OFF_STAT1);
	wire wr_stat2  = reg_wr && (reg_addr == ECCI_OFF_STAT2);
	wire wr_ack    = reg_wr && (reg_addr == ECCI_OFF_ACK); // Any write acknowledges
	wire wr_en_set = reg_wr && (reg_addr == ECCI_OFF_EN_SET);
	wire wr_en_clr = reg_wr && (reg_addr == ECCI_OFF_EN_CLEAR);

	// ==========================================================
	// Injection datapath
	wire single_req = ctrl_reg[ECCI_CTL_SINGLE];
	wire double_req = ctrl_reg[ECCI_CTL_DOUBLE];
	wire force_next = ctrl_reg[ECCI_CTL_FORCE];
	wire one_shot   = ctrl_reg[ECCI_CTL_ONCE];
	wire rmw_en     = ctrl_reg[ECCI_CTL_RMW];
	// Row compare is skipped entirely in force mode
	wire row_match  = force_next || (ram_rd_row == inj_row_reg);
	wire inj_hit    = ram_rd_valid && (single_req || double_req) && row_match;
	wire inj_dbl    = inj_hit && double_req;
	wire [DATA_W-1:0] flip1_data;
	wire [DATA_W-1:0] flip2_data;

	// First bit flips for either kind of injection
	ecci_bit_flip #(.DATA_W(DATA_W), .IDX_W(ECCI_HALF_W)) u_flip_first (
		.data_in  (ram_rd_data),
		.flip_en  (inj_hit),
		.flip_idx (inj_bit1_reg),
		.data_out (flip1_data)
	);

	// Second bit only for double; equal indices cancel, so keep them apart
	ecci_bit_flip #(.DATA_W(DATA_W), .IDX_W(ECCI_HALF_W)) u_flip_second (
		.data_in  (flip1_data),
		.flip_en  (inj_dbl),
		.flip_idx (inj_bit2_reg),
		.data_out (flip2_data)
	);

	// ==========================================================
	// One-shot self clearing of the requests
	// With writeback enabled a single request waits for the writeback to finish
	wire sgl_hit    = inj_hit && single_req && !double_req;
	wire sgl_clear  = one_shot && ((sgl_hit && !rmw_en) || (wb_armed_reg && wb_done));
	wire dbl_clear  = one_shot && inj_dbl;
	wire [ECCI_CTL_W-1:0] hw_clr_mask =
		{{(ECCI_CTL_W-5){1'b0}}, dbl_clear, sgl_clear, 3'h0};
	// A software write in the same cycle wins over the self clear
	assign ctrl_next = wr_ctrl ? reg_wdata[ECCI_CTL_W-1:0] : (ctrl_reg & ~hw_clr_mask);
	assign wb_armed_next = (one_shot && sgl_hit && rmw_en) || (wb_armed_reg && !wb_done);

	// ==========================================================
	// Inject control registers
	assign inj_row_next  = wr_inj1 ? reg_wdata[ECCI_HALF_W-1:0] : inj_row_reg;
	assign inj_bit1_next = wr_inj1 ? reg_wdata[ECCI_HI_LSB +: ECCI_HALF_W] : inj_bit1_reg;
	assign inj_bit2_next = wr_inj2 ? reg_wdata[ECCI_HALF_W-1:0] : inj_bit2_reg;

	// ==========================================================
	// Error capture and pending flags; hardware and software set beat a clear
	wire det_any = det_single || det_double;
	wire [2:0] hw_set = {det_single && wb_pending, det_double, det_single};
	wire [2:0] sw_set = wr_stat1 ? reg_wdata[2:0] : 3'h0;
	wire [2:0] sw_clr = wr_stat1 ? reg_wdata[ECCI_ST_CLR_LSB +: 3] : 3'h0;
	assign flags_next   = hw_set | sw_set | (flags_reg & ~sw_clr);
	assign err_row_next = det_any ? det_row : err_row_reg;
	// Capture beats a software write of the same cycle
	assign err_bit_next = det_single ? det_bit :
		(wr_stat2 ? reg_wdata[ECCI_HALF_W-1:0] : err_bit_reg);

	// ==========================================================
	// Interrupt enables and the acknowledge gate
	// Set and clear sit at different offsets so they never meet in one cycle
	assign enable_next = wr_en_set ? (enable_reg | reg_wdata[NUM_RAMS-1:0]) :
		(wr_en_clr ? (enable_reg & ~reg_wdata[NUM_RAMS-1:0]) : enable_reg);
	wire any_cause = |(pending_reg & enable_reg);
	// Held until acknowledged; a cause still standing re-raises it next cycle
	assign irq_next = wr_ack ? 1'b0 : (irq_reg || any_cause);

	// ==========================================================
	// Read data selection; unmapped offsets read as zero
	wire [31:0] rd_stat1 = {err_row_reg, 5'h00, flags_reg, 5'h00, flags_reg};
	wire [31:0] rd_en_w  = {{(32-NUM_RAMS){1'b0}}, enable_reg};
	wire [31:0] rd_pend  = {{(32-NUM_RAMS){1'b0}}, pending_reg};
	wire [31:0] rd_mux =
		(reg_addr == ECCI_OFF_CTRL)     ? {{(32-ECCI_CTL_W){1'b0}}, ctrl_reg} :
		(reg_addr == ECCI_OFF_INJ1)     ? {inj_bit1_reg, inj_row_reg} :
		(reg_addr == ECCI_OFF_INJ2)     ? {ECCI_HALF_RST, inj_bit2_reg} :
		(reg_addr == ECCI_OFF_STAT1)    ? rd_stat1 :
		(reg_addr == ECCI_OFF_STAT2)    ? {ECCI_HALF_RST, err_bit_reg} :
		(reg_addr == ECCI_OFF_PEND)     ? rd_pend :
		(reg_addr == ECCI_OFF_EN_SET)   ? rd_en_w :
		(reg_addr == ECCI_OFF_EN_CLEAR) ? rd_en_w : ECCI_WORD_RST;

	// ==========================================================
	// Control and status registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg     <= ECCI_CTRL_RST;
			inj_row_reg  <= ECCI_HALF_RST;
			inj_bit1_reg <= ECCI_HALF_RST;
			inj_bit2_reg <= ECCI_HALF_RST;
			err_row_reg  <= ECCI_HALF_RST;
			err_bit_reg  <= ECCI_HALF_RST;
			flags_reg    <= ECCI_FLAG_RST;
			wb_armed_reg <= 1'b0;
		end else begin
			ctrl_reg     <= ctrl_next;
			inj_row_reg  <= inj_row_next;
			inj_bit1_reg <= inj_bit1_next;
			inj_bit2_reg <= inj_bit2_next;
			err_row_reg  <= err_row_next;
			err_bit_reg  <= err_bit_next;
			flags_reg    <= flags_next;
			wb_armed_reg <= wb_armed_next;
		end
	end

	// Interrupt state; pending levels come from same-clock RAM checkers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pending_reg <= '0;
			enable_reg  <= '0;
			irq_reg     <= 1'b0;
		end else begin
			pending_reg <= ram_pending_in;
			enable_reg  <= enable_next;
			irq_reg     <= irq_next;
		end
	end

	// Register read answer one cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg  <= ECCI_WORD_RST;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg  <= reg_rd ? rd_mux : rdata_reg;
			rvalid_reg <= reg_rd;
		end
	end

	// Read path stage; costs one cycle but keeps outputs registered
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid_reg <= 1'b0;
			out_data_reg  <= '0;
			out_inj_reg   <= 1'b0;
		end else begin
			out_valid_reg <= ram_rd_valid;
			out_data_reg  <= flip2_data;
			out_inj_reg   <= inj_hit;
		end
	end

	assign reg_rdata        = rdata_reg;
	assign reg_rvalid       = rvalid_reg;
	assign ram_out_valid    = out_valid_reg;
	assign ram_out_data     = out_data_reg;
	assign ram_out_injected = out_inj_reg;
	assign irq              = irq_reg;

	// ==========================================================
	// Assertions
	wire idx1_ok = inj_bit1_reg < ECCI_HALF_W'(DATA_W);
	wire idx2_ok = inj_bit2_reg < ECCI_HALF_W'(DATA_W);

	single_flip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sgl_hit && idx1_ok |=> $countones(ram_out_data ^ $past(ram_rd_data)) == 1)
		else $error("single injection did not flip one bit");
	row_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ram_rd_valid && !force_next && ram_rd_row != inj_row_reg |=> !ram_out_injected)
		else $error("injection outside the programmed row");
	double_flip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		inj_dbl && idx1_ok && idx2_ok && inj_bit1_reg != inj_bit2_reg
		|=> $countones(ram_out_data ^ $past(ram_rd_data)) == 2)
		else $error("double injection did not flip two bits");
	row_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		det_any |=> err_row_reg == $past(det_row))
		else $error("failing row not captured");
	single_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		det_single |=> flags_reg[ECCI_ST_SINGLE])
		else $error("single flag not set");
	double_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_stat1 && reg_wdata[9] && !reg_wdata[1] && !det_double
		|=> !flags_reg[ECCI_ST_DOUBLE])
		else $error("double flag not cleared");
	succ_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		det_single && wb_pending |=> flags_reg[ECCI_ST_SUCC] [*1] ##0 flags_reg[0])
		else $error("successive flag not set");
	clear_view_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		reg_rvalid && $past(reg_addr) == ECCI_OFF_STAT1
		|-> reg_rdata[10:8] == $past(flags_reg) && reg_rdata[2:0] == $past(flags_reg))
		else $error("clear fields do not mirror flags");
	bit_pos_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		det_single |=> err_bit_reg == $past(det_bit))
		else $error("failing bit index not captured");
	irq_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		irq && !wr_ack |=> irq)
		else $error("interrupt dropped before acknowledge");
	pend_view_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		reg_rd && reg_addr == ECCI_OFF_PEND |=> reg_rdata == {{(32-NUM_RAMS){1'b0}}, $past(pending_reg)})
		else $error("pending vector read wrong");
	en_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_en_set |=> enable_reg == ($past(enable_reg) | $past(reg_wdata[NUM_RAMS-1:0])))
		else $error("enable set wrong");
	en_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_en_clr |=> enable_reg == ($past(enable_reg) & ~$past(reg_wdata[NUM_RAMS-1:0])))
		else $error("enable clear wrong");
	once_dbl_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		dbl_clear && !wr_ctrl |=> !double_req)
		else $error("one-shot double request not cleared");
	irq_cause_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(irq) |-> $past(any_cause) && !$past(irq))
		else $error("interrupt without enabled cause");
	force_hit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ram_rd_valid && force_next && single_req |=> ram_out_injected)
		else $error("forced read not injected");

	inj_done_c: cover property (@(posedge ref_clk) disable iff (!rst_n) ram_out_injected);
	irq_ack_c: cover property (@(posedge ref_clk) disable iff (!rst_n) irq ##1 wr_ack ##1 !irq);
	succ_c: cover property (@(posedge ref_clk) disable iff (!rst_n) flags_reg[ECCI_ST_SUCC]);
	once_c: cover property (@(posedge ref_clk) disable iff (!rst_n) sgl_clear);

endmodule : ecci_monitor

// ### rtl/ecci_pkg.sv
// Register map, field positions and reset values of the ECC inject and status block
package ecci_pkg;

	// ==========================================================
	// Register offsets on the register port (byte addresses)
	localparam logic [7:0] ECCI_OFF_CTRL     = 8'h14;
	localparam logic [7:0] ECCI_OFF_INJ1     = 8'h18;
	localparam logic [7:0] ECCI_OFF_INJ2     = 8'h1c;
	localparam logic [7:0] ECCI_OFF_STAT1    = 8'h20;
	localparam logic [7:0] ECCI_OFF_STAT2    = 8'h24;
	localparam logic [7:0] ECCI_OFF_ACK      = 8'h3c;
	localparam logic [7:0] ECCI_OFF_PEND     = 8'h40;
	localparam logic [7:0] ECCI_OFF_EN_SET   = 8'h80;
	localparam logic [7:0] ECCI_OFF_EN_CLEAR = 8'hc0;

	// ==========================================================
	// Field positions
	localparam int ECCI_CTL_RMW    = 2;
	localparam int ECCI_CTL_SINGLE = 3;
	localparam int ECCI_CTL_DOUBLE = 4;
	localparam int ECCI_CTL_FORCE  = 5;
	localparam int ECCI_CTL_ONCE   = 6;
	localparam int ECCI_CTL_W      = 7;
	localparam int ECCI_HALF_W     = 16;
	localparam int ECCI_HI_LSB     = 16;
	localparam int ECCI_ST_SINGLE  = 0;
	localparam int ECCI_ST_DOUBLE  = 1;
	localparam int ECCI_ST_SUCC    = 2;
	localparam int ECCI_ST_CLR_LSB = 8;
	localparam int ECCI_ACK_BIT    = 0;

	// ==========================================================
	// Reset values
	localparam logic [6:0]  ECCI_CTRL_RST = 7'h07;
	localparam logic [15:0] ECCI_HALF_RST = 16'h0000;
	localparam logic [2:0]  ECCI_FLAG_RST = 3'h0;
	localparam logic [31:0] ECCI_WORD_RST = 32'h0000_0000;

endpackage : ecci_pkg

// ### verif/ecci_testbench.sv
// Self-checking testbench for the ECC inject, status and interrupt block
`timescale 1ns/1ps

module testbench;
	import ecci_pkg::*;

	logic        ref_clk, rst_n, reg_wr, reg_rd, reg_rvalid, ram_rd_valid, ram_out_valid;
	logic        ram_out_injected, det_single, det_double, wb_pending, wb_done, irq;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, ram_rd_data, ram_out_data, d;
	logic [15:0] ram_rd_row, det_row, det_bit, row, i1, i2, r, b;
	logic [18:0] ram_pending_in, en;
	logic [63:0] rd_q[$], ram_q[$];
	int          fail_count, comparisons, k;

	// Offsets that read zero straight after reset
	localparam logic [7:0] ZERO_OFFS [8] = '{ECCI_OFF_INJ1, ECCI_OFF_INJ2, ECCI_OFF_STAT1,
		ECCI_OFF_STAT2, ECCI_OFF_ACK, ECCI_OFF_PEND, ECCI_OFF_EN_SET, 8'h04};

	ecci_monitor dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.ram_rd_valid(ram_rd_valid), .ram_rd_row(ram_rd_row), .ram_rd_data(ram_rd_data),
		.ram_out_valid(ram_out_valid), .ram_out_data(ram_out_data),
		.ram_out_injected(ram_out_injected), .det_single(det_single), .det_double(det_double),
		.det_row(det_row), .det_bit(det_bit), .wb_pending(wb_pending), .wb_done(wb_done),
		.ram_pending_in(ram_pending_in), .irq(irq));

	// ==========================================================
	// Clock and hang guard
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial begin
		#200us;
		fail_count++;
		results();
	end

	// ==========================================================
	// Comparison and verdict
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic results();
		if (fail_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results

	// ==========================================================
	// Output watcher: each result takes the oldest note; an unexpected one meets x
	always @(negedge ref_clk) begin
		if (reg_rvalid === 1'b1) begin
			check({32'h0, reg_rdata}, rd_q.size() > 0 ? rd_q.pop_front() : 'x);
		end
		if (ram_out_valid === 1'b1) begin
			check({31'h0, ram_out_injected, ram_out_data}, ram_q.size() > 0 ? ram_q.pop_front() : 'x);
		end
	end

	// ==========================================================
	// Drivers: strobes rise at one falling edge and drop at the next
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(negedge ref_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		@(negedge ref_clk);
		reg_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(negedge ref_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		rd_q.push_back({32'h0, exp});
		@(negedge ref_clk);
		reg_rd = 1'b0;
	endtask : rd

	task automatic ram(input logic [15:0] rw, input logic [31:0] exp, input logic inj);
		@(negedge ref_clk);
		ram_rd_valid = 1'b1;
		ram_rd_row = rw;
		ram_rd_data = d;
		ram_q.push_back({31'h0, inj, exp});
		@(negedge ref_clk);
		ram_rd_valid = 1'b0;
	endtask : ram

	task automatic det(input logic s, input logic dd, input logic [15:0] rw, input logic [15:0] bt);
		@(negedge ref_clk);
		det_single = s;
		det_double = dd;
		det_row = rw;
		det_bit = bt;
		wb_pending = 1'b1;
		@(negedge ref_clk);
		{det_single, det_double, wb_pending} = 3'h0;
	endtask : det

	// Bounded wait for the interrupt level, then compare it
	task automatic wait_irq(input logic v);
		for (int n = 0; n < 8 && irq !== v; n++) @(negedge ref_clk);
		check({63'h0, irq}, {63'h0, v});
		// A wait that ran out is already counted; stop here
		if (irq !== v) results();
	endtask : wait_irq

	// ==========================================================
	// Main sequence
	initial begin
		{rst_n, reg_wr, reg_rd, ram_rd_valid, det_single, det_double, wb_pending, wb_done} = 8'h0;
		{reg_addr, reg_wdata, ram_rd_row, ram_rd_data, det_row, det_bit} = '0;
		ram_pending_in = 19'h0;
		fail_count = 0;
		comparisons = 0;
		void'($urandom(13));
		repeat (12) @(negedge ref_clk);
		rst_n = 1'b1;
		// Reset values, an unmapped place and the read-only vector
		rd(ECCI_OFF_CTRL, {25'h0, ECCI_CTRL_RST});
		for (k = 0; k < 8; k++) rd(ZERO_OFFS[k], 32'h0);
		wr(8'h04, 32'hffff_ffff);
		wr(ECCI_OFF_PEND, 32'hffff_ffff);
		rd(8'h04, 32'h0);
		rd(ECCI_OFF_PEND, 32'h0);
		// Injection controls and the flipped words
		i1 = 16'($urandom_range(31, 0));
		i2 = 16'((i1 + 1 + $urandom_range(30, 0)) % 32);
		row = 16'($urandom);
		d = $urandom;
		wr(ECCI_OFF_INJ1, {i1, row});
		wr(ECCI_OFF_INJ2, {16'hffff, i2});
		rd(ECCI_OFF_INJ1, {i1, row});
		rd(ECCI_OFF_INJ2, {16'h0, i2});
		wr(ECCI_OFF_CTRL, 32'h0f);
		ram(row, d ^ (32'h1 << i1), 1'b1);
		ram(row + 16'h1, d, 1'b0);
		wr(ECCI_OFF_CTRL, 32'h2f);
		ram(row + 16'h1, d ^ (32'h1 << i1), 1'b1);
		wr(ECCI_OFF_CTRL, 32'h53);
		ram(row, d ^ (32'h1 << i1) ^ (32'h1 << i2), 1'b1);
		ram(row, d, 1'b0);
		rd(ECCI_OFF_CTRL, 32'h43);
		wr(ECCI_OFF_CTRL, 32'h4c);
		ram(row, d ^ (32'h1 << i1), 1'b1);
		rd(ECCI_OFF_CTRL, 32'h4c);
		@(negedge ref_clk) wb_done = 1'b1;
		@(negedge ref_clk) wb_done = 1'b0;
		rd(ECCI_OFF_CTRL, 32'h44);
		// One-shot single without writeback clears at the hit itself
		wr(ECCI_OFF_CTRL, 32'h48);
		ram(row, d ^ (32'h1 << i1), 1'b1);
		ram(row, d, 1'b0);
		rd(ECCI_OFF_CTRL, 32'h40);
		// Detection capture, software set and clear of the flags
		r = 16'($urandom);
		b = 16'($urandom_range(31, 0));
		det(1'b1, 1'b0, r, b);
		rd(ECCI_OFF_STAT1, {r, 16'h0505});
		rd(ECCI_OFF_STAT2, {16'h0, b});
		wr(ECCI_OFF_STAT1, 32'h500);
		rd(ECCI_OFF_STAT1, {r, 16'h0});
		det(1'b0, 1'b1, r ^ 16'h00ff, b ^ 16'h1);
		rd(ECCI_OFF_STAT1, {r ^ 16'h00ff, 16'h0202});
		rd(ECCI_OFF_STAT2, {16'h0, b});
		wr(ECCI_OFF_STAT2, {16'hffff, b ^ 16'h3});
		rd(ECCI_OFF_STAT2, {16'h0, b ^ 16'h3});
		wr(ECCI_OFF_STAT1, 32'h200);
		wr(ECCI_OFF_STAT1, 32'h7);
		rd(ECCI_OFF_STAT1, {r ^ 16'h00ff, 16'h0707});
		wr(ECCI_OFF_STAT1, 32'h700);
		rd(ECCI_OFF_STAT1, {r ^ 16'h00ff, 16'h0});
		// Enables, masking and the acknowledge handshake
		en = 19'($urandom) | 19'h1;
		wr(ECCI_OFF_EN_SET, {13'h0, en});
		wr(ECCI_OFF_EN_SET, 32'h0);
		rd(ECCI_OFF_EN_SET, {13'h0, en});
		wr(ECCI_OFF_EN_CLEAR, {13'h0, en & ~19'h1});
		rd(ECCI_OFF_EN_CLEAR, 32'h1);
		k = $urandom_range(18, 1);
		@(negedge ref_clk) ram_pending_in = 19'h1 << k;
		repeat (5) @(negedge ref_clk);
		check({63'h0, irq}, 64'h0);
		rd(ECCI_OFF_PEND, 32'h1 << k);
		@(negedge ref_clk) ram_pending_in = (19'h1 << k) | 19'h1;
		wait_irq(1'b1);
		@(negedge ref_clk) ram_pending_in = 19'h1 << k;
		repeat (4) @(negedge ref_clk);
		check({63'h0, irq}, 64'h1);
		wr(ECCI_OFF_ACK, $urandom);
		wait_irq(1'b0);
		repeat (4) @(negedge ref_clk);
		check({63'h0, irq}, 64'h0);
		@(negedge ref_clk) ram_pending_in = 19'h1;
		wait_irq(1'b1);
		wr(ECCI_OFF_ACK, 32'h0);
		check({63'h0, irq}, 64'h0);
		wait_irq(1'b1);
		repeat (4) @(negedge ref_clk);
		if (rd_q.size() != 0 || ram_q.size() != 0) fail_count++;
		results();
	end

endmodule : testbench
